// >>> include/pgcr_pkg.sv
// Package: offsets, field positions, reset values and timing for the global config registers
package pgcr_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] PGCR_ADDR_CFG0  = 8'h16;
	localparam logic [7:0] PGCR_ADDR_CFG1  = 8'h17;
	localparam logic [7:0] PGCR_RESET_CFG0 = 8'h18;
	localparam logic [7:0] PGCR_RESET_CFG1 = 8'h00;

	// ************************************************************
	// Field positions, config 0
	// ************************************************************
	localparam int PGCR_B_BLEED_DIS   = 7;
	localparam int PGCR_B_LPR_OVR_EN  = 6;
	localparam int PGCR_B_LPR_OVR_VAL = 5;
	localparam int PGCR_B_LPR_TMR_EN  = 4;
	localparam int PGCR_B_BO_TMR_EN   = 3;
	localparam int PGCR_B_WAKE_DIS    = 2;
	localparam int PGCR_B_OFF_KEEP    = 1;
	localparam int PGCR_B_OFF_FULL    = 0;

	// ************************************************************
	// Field positions, config 1
	// ************************************************************
	localparam int PGCR_B_CFG1_RSVD   = 7;
	localparam int PGCR_B_EREG2_OVR   = 6;
	localparam int PGCR_B_THR_LSB     = 2;
	localparam int PGCR_B_HYS_LSB     = 0;

	// Software power-off codes, {keep_regs, full_reset}
	localparam logic [1:0] PGCR_OFF_NONE = 2'h0;
	localparam logic [1:0] PGCR_OFF_FULL = 2'h1;
	localparam logic [1:0] PGCR_OFF_KEEP = 2'h2;

	// ************************************************************
	// Thresholds in millivolts
	// ************************************************************
	localparam logic [12:0] PGCR_THR_BASE_MV = 13'd2650;
	localparam logic [12:0] PGCR_THR_STEP_MV = 13'd100;
	localparam logic [12:0] PGCR_HYS_BASE_MV = 13'd150;
	localparam logic [12:0] PGCR_HYS_STEP_MV = 13'd50;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int PGCR_CLK_HZ        = 100_000_000;
	localparam int PGCR_SLOW_HZ       = 31_500;
	localparam int PGCR_SLOW_DIV      = PGCR_CLK_HZ / PGCR_SLOW_HZ;
	localparam int PGCR_REL_DELAY_MS  = 20;
	// Least time: rounded up to whole slow ticks
	localparam int PGCR_REL_TICKS     = (PGCR_REL_DELAY_MS * PGCR_SLOW_HZ + 999) / 1000;
	localparam int PGCR_DEBOUNCE_TICKS = 2;
endpackage : pgcr_pkg

// >>> core/pgcr_slow_tick.sv
// Divider producing the slow internal clock enable pulse
module pgcr_slow_tick
	import pgcr_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	output logic      tick_o
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	wire         wrap = (cnt_ff == 16'(PGCR_SLOW_DIV - 1));

	// Count up one slow period
	assign nxt_cnt = wrap ? 16'h0 : cnt_ff + 16'h1;
	assign tick_o  = wrap;

	// ************************************************************
	// Counter
	// ************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) cnt_ff <= 16'h0;
		else         cnt_ff <= nxt_cnt;
	end
endmodule // pgcr_slow_tick

// >>> core/pgcr_global_cfg.sv
// Global configuration registers 0 and 1 with low-power request control
// Notes on behaviour
// [R01] Bleed disable bit 0 keeps bleed on in deep sleep; 1 turns it off.
// [R02] Override enable 0: control logic drives request; 1: register drives it. Code honours the override only while slave_mode_i is high.
// [R03] Under override, value 0 pulls request low, value 1 releases it high.
// [R04] Release timer 0 deasserts at exit start; 1 deasserts 20ms later.
// [R05] Request falls one slow tick after debounced falling edge of mode input.
// [R06] Brownout timer bit 0: brownout state held until recovery or power-down.
// [R07] Brownout timer bit 1: leave brownout on timer expiry or power-down.
// [R08] Wake disable 1 keeps device off even above reset threshold.
// [R09] Power-off code 01 full reset, 10 keep registers, 00 nothing.
// [R10] Power-off bits are write-only and self-clearing.
// [R11] Regulator-2 override 1: output follows mode bits, pull-up forced off.
// [R12] Reset threshold code maps 2650mV plus 100mV per step.
// [R13] Hysteresis code maps 150mV plus 50mV per step.
// [R14] Software writes zero to reserved bit 7 and ignores its read.
// [R15] Any power-off bit written 1 sets flag; flag clears on read.
// [R16] Power-off code 11 does nothing. Code starts no action for it but still sets the flag.
module pgcr_global_cfg
	import pgcr_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        flag_rd_i,
	output logic             soft_off_flag_o,
	output logic             soft_off_full_reset_o,
	output logic             soft_off_keep_regs_o,
	input  wire logic        slave_mode_i,
	input  wire logic        lowpower_mode_in_i,
	input  wire logic        deep_sleep_state_i,
	input  wire logic        sleep_exit_start_i,
	input  wire logic        control_logic_lpreq_i,
	output logic             lowpower_request_out_o,
	output logic             lowpower_request_oe_o,
	output logic             bleed_enable_o,
	output logic             bleed_cmp_enable_o,
	input  wire logic        brownout_state_i,
	input  wire logic        sys_above_bo_rise_i,
	input  wire logic        power_down_cond_i,
	input  wire logic        brownout_timer_expired_i,
	output logic             brownout_exit_o,
	output logic             brownout_start_pd_o,
	input  wire logic        sys_above_reset_i,
	input  wire logic        off_state_i,
	output logic             power_up_start_o,
	input  wire logic        control_logic_ereg2_i,
	input  wire logic [1:0]  operating_mode_bits_i,
	output logic             ext_reg2_enable_out_o,
	output logic             ext_reg2_pullup_en_o,
	output logic      [12:0] sys_reset_threshold_mv_o,
	output logic      [12:0] sys_reset_hysteresis_mv_o
);
	// ************************************************************
	// Storage and decode
	// ************************************************************
	logic [7:0] cfg0_ff;
	logic [7:0] cfg1_ff;
	logic [7:0] nxt_cfg0;
	logic [7:0] nxt_cfg1;
	logic       flag_ff;
	logic       full_ff;
	logic       keep_ff;

	wire        wr_cfg0 = reg_wr_i && (reg_addr_i == PGCR_ADDR_CFG0);
	wire        wr_cfg1 = reg_wr_i && (reg_addr_i == PGCR_ADDR_CFG1);
	wire  [1:0] off_code = {reg_wdata_i[PGCR_B_OFF_KEEP], reg_wdata_i[PGCR_B_OFF_FULL]};
	wire        off_wr   = wr_cfg0 && (off_code != PGCR_OFF_NONE);

	// Power-off bits never stored: they only pulse the action
	assign nxt_cfg0 = wr_cfg0 ? {reg_wdata_i[7:2], 2'h0} : cfg0_ff; // [R10]
	assign nxt_cfg1 = wr_cfg1 ? reg_wdata_i : cfg1_ff;

	// Reads: power-off bits return zero; reserved bit returned as stored
	assign reg_rdata_o = (reg_addr_i == PGCR_ADDR_CFG0) ? cfg0_ff :
	                     (reg_addr_i == PGCR_ADDR_CFG1) ? cfg1_ff : 8'h00; // [R14]

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cfg0_ff <= PGCR_RESET_CFG0;
			cfg1_ff <= PGCR_RESET_CFG1;
		end else begin
			cfg0_ff <= nxt_cfg0;
			cfg1_ff <= nxt_cfg1;
		end
	end

	// ************************************************************
	// Software power-off
	// ************************************************************
	// Code 11 is undefined, so it starts nothing
	wire go_full = wr_cfg0 && (off_code == PGCR_OFF_FULL); // [R09] [R16]
	wire go_keep = wr_cfg0 && (off_code == PGCR_OFF_KEEP); // [R09] [R16]

	// One-cycle action pulses, then cleared
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			full_ff <= 1'b0;
			keep_ff <= 1'b0;
		end else begin
			full_ff <= go_full; // [R10]
			keep_ff <= go_keep; // [R10]
		end
	end
	assign soft_off_full_reset_o = full_ff;
	assign soft_off_keep_regs_o  = keep_ff;

	// Flag: set wins over clear-on-read, so no write is lost
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)        flag_ff <= 1'b0;
		else if (off_wr)    flag_ff <= 1'b1; // [R15]
		else if (flag_rd_i) flag_ff <= 1'b0; // [R15]
	end
	assign soft_off_flag_o = flag_ff;

	// ************************************************************
	// Bleed and on/off steering
	// ************************************************************
	wire bleed_dis = cfg0_ff[PGCR_B_BLEED_DIS];
	assign bleed_enable_o     = deep_sleep_state_i && !bleed_dis; // [R01]
	assign bleed_cmp_enable_o = sleep_exit_start_i && !bleed_dis; // [R01]

	wire bo_tmr = cfg0_ff[PGCR_B_BO_TMR_EN];
	// Timer expiry only counts when the timer is enabled
	assign brownout_exit_o     = brownout_state_i && sys_above_bo_rise_i
	                             && !power_down_cond_i; // [R06]
	assign brownout_start_pd_o = brownout_state_i && (power_down_cond_i
	                             || (bo_tmr && brownout_timer_expired_i)); // [R06] [R07]

	assign power_up_start_o = off_state_i && sys_above_reset_i
	                          && !cfg0_ff[PGCR_B_WAKE_DIS]; // [R08]

	// ************************************************************
	// Regulator 2 enable
	// ************************************************************
	wire ereg2_ovr = cfg1_ff[PGCR_B_EREG2_OVR];
	assign ext_reg2_enable_out_o = ereg2_ovr ? (operating_mode_bits_i != 2'h0)
	                                         : control_logic_ereg2_i; // [R11]
	assign ext_reg2_pullup_en_o  = !ereg2_ovr; // [R11]

	// ************************************************************
	// Threshold decode
	// ************************************************************
	wire [3:0] thr_code = cfg1_ff[PGCR_B_THR_LSB +: 4];
	wire [1:0] hys_code = cfg1_ff[PGCR_B_HYS_LSB +: 2];
	assign sys_reset_threshold_mv_o  = PGCR_THR_BASE_MV
	                                   + 13'(thr_code) * PGCR_THR_STEP_MV; // [R12]
	assign sys_reset_hysteresis_mv_o = PGCR_HYS_BASE_MV
	                                   + 13'(hys_code) * PGCR_HYS_STEP_MV; // [R13]

	// ************************************************************
	// Low-power request
	// ************************************************************
	logic        tick;
	logic [1:0]  mode_sh_ff;
	logic        mode_db_ff;
	logic        fall_pend_ff;
	logic        req_ff;
	logic        rel_pend_ff;
	logic [10:0] rel_cnt_ff;

	pgcr_slow_tick u_tick (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.tick_o    (tick)
	);

	// Debounce: input must agree on consecutive slow ticks
	wire mode_stable = (mode_sh_ff[0] == lowpower_mode_in_i) && (mode_sh_ff[1] == mode_sh_ff[0]);
	wire db_fall     = tick && mode_stable && mode_db_ff && !lowpower_mode_in_i;
	wire tmr_en      = cfg0_ff[PGCR_B_LPR_TMR_EN];
	wire rel_done    = rel_pend_ff && tick && (rel_cnt_ff == 11'(PGCR_REL_TICKS - 1));

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			// Start at the pin's idle high level, so no false edge follows reset
			mode_sh_ff <= 2'h3;
			mode_db_ff <= 1'b1;
		end else if (tick) begin
			mode_sh_ff <= {mode_sh_ff[0], lowpower_mode_in_i};
			if (mode_stable) mode_db_ff <= lowpower_mode_in_i;
		end
	end

	// Falling edge lowers the request on the following slow tick
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)                    fall_pend_ff <= 1'b0;
		else if (db_fall)               fall_pend_ff <= 1'b1;
		else if (tick)                  fall_pend_ff <= 1'b0; // [R05]
	end

	// Release timer counts slow ticks from the exit flow start
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rel_pend_ff <= 1'b0;
			rel_cnt_ff  <= 11'h0;
		end else if (sleep_exit_start_i && tmr_en) begin
			rel_pend_ff <= 1'b1; // [R04]
			rel_cnt_ff  <= 11'h0;
		end else if (rel_done) begin
			rel_pend_ff <= 1'b0;
		end else if (rel_pend_ff && tick) begin
			rel_cnt_ff  <= rel_cnt_ff + 11'h1;
		end
	end

	// Request level: low asks for low power, high is released (deasserted)
	// Only the exit flow releases it, so a rising mode pin cannot cut the timer short
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)                               req_ff <= 1'b1;
		else if (fall_pend_ff && tick)             req_ff <= 1'b0; // [R05]
		else if (sleep_exit_start_i && !tmr_en)    req_ff <= 1'b1; // [R04]
		else if (rel_done)                         req_ff <= 1'b1; // [R04]
	end

	// Override only honoured in slave operation
	wire ovr_on   = cfg0_ff[PGCR_B_LPR_OVR_EN] && slave_mode_i; // [R02]
	wire pin_high = ovr_on ? cfg0_ff[PGCR_B_LPR_OVR_VAL] // [R03]
	                       : (req_ff && control_logic_lpreq_i); // [R02]
	// Open drain: drive only when pulling low
	assign lowpower_request_out_o = 1'b0;
	assign lowpower_request_oe_o  = !pin_high; // [R03]
endmodule // pgcr_global_cfg

// >>> verification/pgcr_global_cfg_sva.sv
// Checker: port-level properties of the global configuration registers
module pgcr_global_cfg_chk
	import pgcr_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	input wire logic        reg_wr_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        flag_rd_i,
	input wire logic        soft_off_flag_o,
	input wire logic        soft_off_full_reset_o,
	input wire logic        soft_off_keep_regs_o,
	input wire logic        slave_mode_i,
	input wire logic        lowpower_request_oe_o,
	input wire logic        sys_above_reset_i,
	input wire logic        power_up_start_o,
	input wire logic [1:0]  operating_mode_bits_i,
	input wire logic        ext_reg2_enable_out_o,
	input wire logic        ext_reg2_pullup_en_o,
	input wire logic [12:0] sys_reset_threshold_mv_o,
	input wire logic [12:0] sys_reset_hysteresis_mv_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Write decodes; a set write beats a flag read in the same cycle
	wire logic wr0 = reg_wr_i && (reg_addr_i == PGCR_ADDR_CFG0);
	wire logic wr1 = reg_wr_i && (reg_addr_i == PGCR_ADDR_CFG1);
	wire logic off_set = wr0 && (reg_wdata_i[1] | reg_wdata_i[0]);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	property p_full; wr0 |=> soft_off_full_reset_o == ($past(reg_wdata_i[1:0]) == 2'h1); endproperty
	a_full: assert property (p_full) else $error("full reset pulse wrong");
	property p_keep; wr0 |=> soft_off_keep_regs_o == ($past(reg_wdata_i[1:0]) == 2'h2); endproperty
	a_keep: assert property (p_keep) else $error("keep regs pulse wrong");
	property p_fset; soft_off_full_reset_o || soft_off_keep_regs_o |-> soft_off_flag_o; endproperty
	a_fset: assert property (p_fset) else $error("flag not set");
	property p_fclr; flag_rd_i && !off_set |=> !soft_off_flag_o; endproperty
	a_fclr: assert property (p_fclr) else $error("flag not cleared");
	property p_wo; reg_addr_i == PGCR_ADDR_CFG0 |-> reg_rdata_o[1:0] == 2'h0; endproperty
	a_wo: assert property (p_wo) else $error("power-off bits readable");
	property p_thr; wr1 |=> sys_reset_threshold_mv_o == 13'd2650 + 13'd100 * $past(reg_wdata_i[5:2]);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold mapping wrong");
	property p_hys; wr1 |=> sys_reset_hysteresis_mv_o == 13'd150 + 13'd50 * $past(reg_wdata_i[1:0]);
	endproperty
	a_hys: assert property (p_hys) else $error("hysteresis mapping wrong");
	property p_ereg; wr1 && reg_wdata_i[6] |=> ext_reg2_enable_out_o == (operating_mode_bits_i != 2'h0)
		&& !ext_reg2_pullup_en_o; endproperty
	a_ereg: assert property (p_ereg) else $error("regulator 2 override wrong");
	property p_ovr; wr0 && reg_wdata_i[6] ##1 slave_mode_i |-> lowpower_request_oe_o == !$past(reg_wdata_i[5]);
	endproperty
	a_ovr: assert property (p_ovr) else $error("request override wrong");
	property p_wake; power_up_start_o |-> sys_above_reset_i; endproperty
	a_wake: assert property (p_wake) else $error("power-up without voltage");
	property p_wake_dis; wr0 && reg_wdata_i[PGCR_B_WAKE_DIS] |=> !power_up_start_o; endproperty
	a_wake_dis: assert property (p_wake_dis) else $error("wake disable ignored");
endmodule // pgcr_global_cfg_chk

bind pgcr_global_cfg pgcr_global_cfg_chk pgcr_global_cfg_chk_inst (.clk_sys_i, .reset_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .flag_rd_i, .soft_off_flag_o, .soft_off_full_reset_o,
	.soft_off_keep_regs_o, .slave_mode_i, .lowpower_request_oe_o, .sys_above_reset_i, .power_up_start_o,
	.operating_mode_bits_i, .ext_reg2_enable_out_o, .ext_reg2_pullup_en_o, .sys_reset_threshold_mv_o,
	.sys_reset_hysteresis_mv_o);

// >>> verification/pgcr_host_model.sv
// Host-side model: drives the low-power mode pin, sees the open-drain request pin
module pgcr_host_model
(
	input  wire logic clk_sys_i,
	input  wire logic sleep_i,
	input  wire logic req_oe_i,
	output logic      lowpower_mode_o,
	output logic      req_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Mode pin idles high; host lowers it to ask for sleep, just after an edge
	initial begin
		lowpower_mode_o = 1'b1;
		forever @(posedge clk_sys_i) lowpower_mode_o <= ~sleep_i;
	end
	// Pull-up on the wire: released means high, never left floating
	assign req_pin_o = req_oe_i ? 1'b0 : 1'b1;
endmodule // pgcr_host_model

// >>> verification/pgcr_global_cfg_tb.sv
// Testbench: register access, decode outputs and low-power handshake
module pgcr_global_cfg_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pgcr_pkg::*;
	logic clk_sys_i, reset_i, reg_wr_i, reg_rd_i, flag_rd_i, slave_mode_i, lowpower_mode_in_i;
	logic deep_sleep_state_i, sleep_exit_start_i, control_logic_lpreq_i, brownout_state_i;
	logic sys_above_bo_rise_i, power_down_cond_i, brownout_timer_expired_i, sys_above_reset_i;
	logic off_state_i, control_logic_ereg2_i, sleep, req_pin, soft_off_flag_o, soft_off_full_reset_o;
	logic soft_off_keep_regs_o, lowpower_request_out_o, lowpower_request_oe_o, bleed_enable_o;
	logic bleed_cmp_enable_o, brownout_exit_o, brownout_start_pd_o, power_up_start_o;
	logic ext_reg2_enable_out_o, ext_reg2_pullup_en_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [1:0] operating_mode_bits_i;
	logic [12:0] sys_reset_threshold_mv_o, sys_reset_hysteresis_mv_o;
	int n_fail, n_tests;
	pgcr_global_cfg pgcr_global_cfg_inst (.clk_sys_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
		.reg_wdata_i, .reg_rdata_o, .flag_rd_i, .soft_off_flag_o, .soft_off_full_reset_o,
		.soft_off_keep_regs_o, .slave_mode_i, .lowpower_mode_in_i, .deep_sleep_state_i,
		.sleep_exit_start_i, .control_logic_lpreq_i, .lowpower_request_out_o, .lowpower_request_oe_o,
		.bleed_enable_o, .bleed_cmp_enable_o, .brownout_state_i, .sys_above_bo_rise_i,
		.power_down_cond_i, .brownout_timer_expired_i, .brownout_exit_o, .brownout_start_pd_o,
		.sys_above_reset_i, .off_state_i, .power_up_start_o, .control_logic_ereg2_i,
		.operating_mode_bits_i, .ext_reg2_enable_out_o, .ext_reg2_pullup_en_o,
		.sys_reset_threshold_mv_o, .sys_reset_hysteresis_mv_o);
	pgcr_host_model pgcr_host_model_inst (.clk_sys_i, .sleep_i(sleep), .req_oe_i(lowpower_request_oe_o),
		.lowpower_mode_o(lowpower_mode_in_i), .req_pin_o(req_pin));
	// 100 MHz clock
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// ************************************************************
	// Bus tasks and comparison
	// ************************************************************
	task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe; returns while any pulse it caused is visible
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		#1 cmp(13'(reg_rdata_o), 13'(e));
	endtask
	// Bounded wait on the open-drain pin level
	task automatic wait_pin(input logic v);
		int i;
		for (i = 0; i < 20000 && req_pin !== v; i++) @(negedge clk_sys_i);
		cmp(req_pin, v);
		if (i >= 20000) report_and_stop();
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{reg_wr_i, reg_rd_i, flag_rd_i, slave_mode_i, deep_sleep_state_i, sleep_exit_start_i} = '0;
		{brownout_state_i, sys_above_bo_rise_i, power_down_cond_i, brownout_timer_expired_i} = '0;
		{sys_above_reset_i, off_state_i, control_logic_ereg2_i, sleep, reg_addr_i, reg_wdata_i} = '0;
		{n_fail, n_tests, operating_mode_bits_i} = '0;
		control_logic_lpreq_i = 1'b1;
		reset_i = 1'b1;
		repeat (16) @(negedge clk_sys_i);
		reset_i = 1'b0;
		rd(PGCR_ADDR_CFG0, PGCR_RESET_CFG0);
		rd(PGCR_ADDR_CFG1, PGCR_RESET_CFG1);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		rd(PGCR_ADDR_CFG0, PGCR_RESET_CFG0);
		$display("test reset_map done");
		for (int c = 0; c < 4; c++) begin
			wr(PGCR_ADDR_CFG0, 8'h18 | 8'(c));
			cmp(soft_off_full_reset_o, c == 1);
			cmp(soft_off_keep_regs_o, c == 2);
			cmp(soft_off_flag_o, c != 0);
			rd(PGCR_ADDR_CFG0, 8'h18);
			@(negedge clk_sys_i);
			cmp(soft_off_full_reset_o | soft_off_keep_regs_o, 1'b0);
			flag_rd_i = 1'b1;
			@(negedge clk_sys_i);
			flag_rd_i = 1'b0;
			cmp(soft_off_flag_o, 1'b0);
		end
		$display("test soft_off done");
		for (int t = 0; t < 16; t++) begin
			wr(PGCR_ADDR_CFG1, {2'b00, 4'(t), 2'(t)});
			cmp(sys_reset_threshold_mv_o, 13'd2650 + 13'd100 * 13'(t));
			cmp(sys_reset_hysteresis_mv_o, 13'd150 + 13'd50 * 13'(t % 4));
			rd(PGCR_ADDR_CFG1, {2'b00, 4'(t), 2'(t)});
		end
		$display("test thresholds done");
		deep_sleep_state_i = 1'b1;
		wr(PGCR_ADDR_CFG0, 8'h80);
		cmp(bleed_enable_o, 1'b0);
		sleep_exit_start_i = 1'b1;
		#1 cmp(bleed_cmp_enable_o, 1'b0);
		sleep_exit_start_i = 1'b0;
		wr(PGCR_ADDR_CFG0, 8'h00);
		cmp(bleed_enable_o, 1'b1);
		sleep_exit_start_i = 1'b1;
		#1 cmp(bleed_cmp_enable_o, 1'b1);
		sleep_exit_start_i = 1'b0;
		slave_mode_i = 1'b1;
		wr(PGCR_ADDR_CFG0, 8'h40);
		cmp(req_pin, 1'b0);
		cmp(lowpower_request_out_o, 1'b0);
		wr(PGCR_ADDR_CFG0, 8'h60);
		cmp(req_pin, 1'b1);
		slave_mode_i = 1'b0;
		wr(PGCR_ADDR_CFG0, 8'h40);
		control_logic_lpreq_i = 1'b0;
		#1 cmp(req_pin, 1'b0);
		control_logic_lpreq_i = 1'b1;
		#1 cmp(req_pin, 1'b1);
		$display("test bleed_override done");
		wr(PGCR_ADDR_CFG1, 8'h40);
		operating_mode_bits_i = 2'b10;
		#1 cmp({ext_reg2_enable_out_o, ext_reg2_pullup_en_o}, 2'b10);
		operating_mode_bits_i = 2'b00;
		#1 cmp(ext_reg2_enable_out_o, 1'b0);
		wr(PGCR_ADDR_CFG1, 8'h00);
		control_logic_ereg2_i = 1'b1;
		#1 cmp(ext_reg2_enable_out_o, 1'b1);
		{off_state_i, sys_above_reset_i} = 2'b11;
		wr(PGCR_ADDR_CFG0, 8'h00);
		cmp(power_up_start_o, 1'b1);
		wr(PGCR_ADDR_CFG0, 8'h04);
		cmp(power_up_start_o, 1'b0);
		{brownout_state_i, brownout_timer_expired_i} = 2'b11;
		wr(PGCR_ADDR_CFG0, 8'h00);
		cmp(brownout_start_pd_o, 1'b0);
		sys_above_bo_rise_i = 1'b1;
		#1 cmp(brownout_exit_o, 1'b1);
		wr(PGCR_ADDR_CFG0, 8'h08);
		cmp(brownout_start_pd_o, 1'b1);
		{brownout_timer_expired_i, power_down_cond_i} = 2'b01;
		#1 cmp(brownout_start_pd_o, 1'b1);
		$display("test ereg_wake_brownout done");
		{brownout_state_i, power_down_cond_i, sys_above_bo_rise_i} = '0;
		wr(PGCR_ADDR_CFG0, 8'h00);
		sleep = 1'b1;
		wait_pin(1'b0);
		sleep = 1'b0;
		sleep_exit_start_i = 1'b1;
		@(negedge clk_sys_i);
		sleep_exit_start_i = 1'b0;
		wait_pin(1'b1);
		// Let the high mode level settle through the debounce before asking again
		repeat (4 * PGCR_SLOW_DIV) @(negedge clk_sys_i);
		wr(PGCR_ADDR_CFG0, 8'h10);
		sleep = 1'b1;
		wait_pin(1'b0);
		sleep = 1'b0;
		sleep_exit_start_i = 1'b1;
		@(negedge clk_sys_i);
		sleep_exit_start_i = 1'b0;
		// Timer on: the request must still be held well inside the release delay
		repeat (1000) @(negedge clk_sys_i);
		cmp(req_pin, 1'b0);
		$display("test lowpower done");
		report_and_stop();
	end
endmodule // pgcr_global_cfg_tb
